// ---- include/sram_host_pkg.sv ----
package sram_host_pkg;
  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 32768;

  // ****************************************
  // Timing, in ns for the slowest grade
  // ****************************************
  localparam int CLK_PERIOD_NS          = 25;
  localparam int READ_CYCLE_MIN_NS      = 25;
  localparam int SELECT_ACCESS_MAX_NS   = 25;
  localparam int DRIVE_ENABLE_ACCESS_NS = 8;
  localparam int DESELECT_TO_HIGH_Z_NS  = 9;
  localparam int DRIVE_DIS_TO_HIGH_Z_NS = 7;
  localparam int WRITE_CYCLE_MIN_NS     = 25;
  localparam int SELECT_TO_WRITE_END_NS = 15;
  localparam int ADDR_VALID_TO_END_NS   = 15;
  localparam int STROBE_LOW_TO_HIGH_Z_NS = 10;

  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Sample one cycle after access time, so add a cycle of margin to the read access count
  localparam int READ_ACCESS_CYC = ceil_cycles(SELECT_ACCESS_MAX_NS) + 1;
  localparam int READ_CYCLE_CYC  = ceil_cycles(READ_CYCLE_MIN_NS);
  localparam int WRITE_LOW_CYC   = ceil_cycles(SELECT_TO_WRITE_END_NS);
  localparam int WRITE_CYCLE_CYC = ceil_cycles(WRITE_CYCLE_MIN_NS);
  localparam int TURN_CYC        = ceil_cycles(DESELECT_TO_HIGH_Z_NS);
  localparam int CNT_W           = 4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RSEL  = 3'b001,
    ST_RHOLD = 3'b011,
    ST_WSET  = 3'b100,
    ST_WLOW  = 3'b101,
    ST_WEND  = 3'b111,
    ST_TURN  = 3'b010
  } sram_state_e;
endpackage

// ---- sim/sram_mem_model.sv ----
`timescale 1ns/1ps
module sram_mem_model (
  input  wire logic [14:0] address_pins,
  input  wire logic        select_n,
  input  wire logic        drive_enable_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  bus,
  input  wire logic        slow,
  output logic [7:0]       mem_out,
  output logic             mem_drv
);
  logic [7:0] mem [0:32767];
  logic       wr_act;
  logic       rd_en;
  assign wr_act = !select_n && !write_strobe_n;
  // Powered the moment select falls, so reads need no extra wake-up time
  assign rd_en  = !select_n && !drive_enable_n && write_strobe_n;
  initial begin
    mem_drv = 1'b0;
    mem_out = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Byte lands when the first of the pair rises
  always @(negedge wr_act) mem[address_pins] = bus;
  // Turn-on waits 2 ns so the tail of a write is never driven over
  always @(rd_en) begin
    if (!rd_en) mem_drv = 1'b0;
    else #2 mem_drv = rd_en;
  end
  // Slow parts show a wrong byte until just inside the access time
  always @(posedge rd_en) begin
    mem_out = ~mem[address_pins];
    #(slow ? 24 : 3) mem_out = mem[address_pins];
  end
endmodule

// ---- sim/test_sram_host.sv ----
`timescale 1ns/1ps
module test_sram_host;
  typedef struct packed {
    logic        w;
    logic [14:0] a;
    logic [7:0]  d;
  } row_s;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0]  req_wdata = 8'h00;
  logic        slow = 1'b0;
  logic [7:0]  noise = 8'h3c;
  logic        req_ready, rsp_valid, select_n, drive_enable_n, write_strobe_n, oe_n, mem_drv;
  logic [7:0]  rsp_rdata, dout, mem_out, bus, rd;
  logic [14:0] address_pins;
  int          num_errors = 0;
  int          cmp_count = 0;
  row_s        rows [8] = '{'{1'b1, 15'h0000, 8'h5a}, '{1'b1, 15'h7fff, 8'ha5}, '{1'b0, 15'h0000, 8'h5a},
                            '{1'b0, 15'h7fff, 8'ha5}, '{1'b1, 15'h4000, 8'hff}, '{1'b1, 15'h4000, 8'h00},
                            '{1'b0, 15'h4000, 8'h00}, '{1'b0, 15'h0001, 8'h00}};

  always #12.5 core_clk = ~core_clk;
  // A released bus wanders, so a late sample cannot pass by luck
  always @(posedge core_clk) noise <= noise + 8'h5b;
  assign bus = !oe_n ? dout : (mem_drv ? mem_out : noise);

  sram_host i_sram_host (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .address_pins(address_pins), .select_n(select_n), .drive_enable_n(drive_enable_n),
    .write_strobe_n(write_strobe_n), .data_bus_pins_i(bus), .data_bus_pins_o(dout), .data_bus_pins_oe_n(oe_n));
  sram_mem_model i_sram_mem_model (.address_pins(address_pins), .select_n(select_n),
    .drive_enable_n(drive_enable_n), .write_strobe_n(write_strobe_n), .bus(bus), .slow(slow),
    .mem_out(mem_out), .mem_drv(mem_drv));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Both sides driving the bus at once
  always @(posedge core_clk) if (rst_n && !oe_n && mem_drv) check(8'h01, 8'h00);

  task automatic op(input row_s r, output logic [7:0] q);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #2;
      n++;
    end while (!req_ready && n < 20);
    if (!req_ready) begin
      num_errors++;
      results();
    end
    req_valid = 1'b1;
    req_write = r.w;
    req_addr  = r.a;
    req_wdata = r.d;
    @(posedge core_clk);
    #2 req_valid = 1'b0;
    for (n = 1; n <= 20; n++) begin
      @(posedge core_clk);
      #1;
      if (r.w ? req_ready : rsp_valid) break;
    end
    if (n > 20) begin
      num_errors++;
      results();
    end
    // Counted at the edge that launches the answer: ready after a write, rsp_valid after a read
    check(8'(n), r.w ? 8'h04 : 8'h05);
    q = rsp_rdata;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    check({2'b00, req_ready, rsp_valid, select_n, drive_enable_n, write_strobe_n, oe_n}, 8'h2f);
    #2 rst_n = 1'b1;
    $display("reset test done");
    foreach (rows[i]) begin
      op(rows[i], rd);
      if (!rows[i].w) check(rd, rows[i].d);
      $display("row %0d done", i);
    end
    // A request held while busy must not be taken
    @(posedge core_clk);
    #2 req_valid = 1'b1;
    req_write = 1'b1;
    req_addr  = 15'h0002;
    req_wdata = 8'h11;
    @(posedge core_clk);
    #2 req_addr = 15'h0001;
    req_wdata = 8'h77;
    check({7'h00, req_ready}, 8'h00);
    repeat (2) @(posedge core_clk);
    #2 req_valid = 1'b0;
    op('{1'b0, 15'h0001, 8'h00}, rd);
    check(rd, 8'h00);
    op('{1'b0, 15'h0002, 8'h00}, rd);
    check(rd, 8'h11);
    $display("busy refusal test done");
    slow = 1'b1;
    op('{1'b0, 15'h7fff, 8'h00}, rd);
    check(rd, 8'ha5);
    check({5'h00, select_n, drive_enable_n, oe_n}, 8'h07);
    $display("slow read test done");
    // Reset in mid-write must drop every strobe and release the bus within two clock edges
    @(posedge core_clk);
    #2 req_valid = 1'b1;
    req_write = 1'b1;
    req_addr  = 15'h0003;
    req_wdata = 8'h3c;
    @(posedge core_clk);
    #2 req_valid = 1'b0;
    @(posedge core_clk);
    #2 check({7'h00, write_strobe_n}, 8'h00);
    rst_n = 1'b0;
    // Held over two edges so no edge check sees the cut write end
    repeat (2) @(posedge core_clk);
    #2 check({2'b00, req_ready, rsp_valid, select_n, drive_enable_n, write_strobe_n, oe_n}, 8'h2f);
    rst_n = 1'b1;
    op('{1'b1, 15'h0003, 8'h3c}, rd);
    op('{1'b0, 15'h0003, 8'h00}, rd);
    check(rd, 8'h3c);
    $display("mid-run reset test done");
    results();
  end
endmodule

// ---- src/sram_host.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Write happens while select and strobe are both low; bus carries data in.
// - Read happens with strobe high, select and drive enable low.
// - Successive reads spaced at least the read cycle minimum.
// - Successive writes spaced at least the write cycle minimum.
// - Select held low at least select-to-write-end before write ends.
// - Reduced-power parts need the longer select-to-write-end figure.
// - Address stable at least addr-valid-to-write-end before write ends.
// - Write spans the overlap of select and strobe low.
module sram_host
  import sram_host_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  output logic               req_ready,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  output logic [AW-1:0]      address_pins,
  output logic               select_n,
  output logic               drive_enable_n,
  output logic               write_strobe_n,
  input  wire logic [DW-1:0] data_bus_pins_i,
  output logic [DW-1:0]      data_bus_pins_o,
  output logic               data_bus_pins_oe_n
);
  import sram_host_pkg::*;

  // ****************************************
  // Sequencer
  // ****************************************
  sram_state_e      state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DW-1:0]    rd_meta_q;
  logic [DW-1:0]    rd_sync_q;

  assign req_ready = (state_q == ST_IDLE);

  // Control pins stay high between cycles, so the memory idles in standby
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid) begin
            state_q <= req_write ? ST_WSET : ST_RSEL;
          end
        end
        ST_RSEL: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(READ_ACCESS_CYC + 1)) begin
            state_q <= ST_RHOLD;
          end
        end
        ST_RHOLD: begin
          cnt_q   <= '0;
          state_q <= ST_TURN;
        end
        ST_WSET: begin
          cnt_q   <= '0;
          state_q <= ST_WLOW;
        end
        ST_WLOW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WRITE_LOW_CYC - 1)) begin
            state_q <= ST_WEND;
          end
        end
        ST_WEND: begin
          cnt_q   <= '0;
          state_q <= ST_TURN;
        end
        ST_TURN: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(TURN_CYC - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      address_pins       <= '0;
      data_bus_pins_o    <= '0;
      select_n           <= 1'b1;
      drive_enable_n     <= 1'b1;
      write_strobe_n     <= 1'b1;
      data_bus_pins_oe_n <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          select_n           <= 1'b1;
          drive_enable_n     <= 1'b1;
          write_strobe_n     <= 1'b1;
          data_bus_pins_oe_n <= 1'b1;
          if (req_valid) begin
            address_pins    <= req_addr;
            data_bus_pins_o <= req_wdata;
            select_n        <= 1'b0;
            drive_enable_n  <= req_write;
          end
        end
        ST_WSET: begin
          write_strobe_n     <= 1'b0;
          data_bus_pins_oe_n <= 1'b0;
        end
        ST_WEND: begin
          // Strobe and select rise together; data and address held one more cycle
          write_strobe_n <= 1'b1;
          select_n       <= 1'b1;
        end
        ST_RHOLD: begin
          select_n       <= 1'b1;
          drive_enable_n <= 1'b1;
        end
        ST_TURN: begin
          // Bus released last, after strobe rise, so neither side fights
          data_bus_pins_oe_n <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read capture
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_meta_q <= '0;
      rd_sync_q <= '0;
    end else begin
      rd_meta_q <= data_bus_pins_i;
      rd_sync_q <= rd_meta_q;
    end
  end

  // Data was stable through the access window, so the synchroniser delay is harmless
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_q == ST_RHOLD);
      if (state_q == ST_RHOLD) begin
        rsp_rdata <= rd_sync_q;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_no_bus_fight: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(data_bus_pins_oe_n == 1'b0 && drive_enable_n == 1'b0))
    else $error("Host drives bus while memory output enabled");

  a_write_overlap: assert property (@(posedge core_clk) disable iff (!rst_n)
    !write_strobe_n |-> !select_n)
    else $error("Strobe low without select");

  a_strobe_width: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(write_strobe_n) |-> !write_strobe_n [*2])
    else $error("Write strobe too short");

  a_addr_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
    !write_strobe_n |-> $stable(address_pins))
    else $error("Address moved during write");

  a_data_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(write_strobe_n) |-> $stable(data_bus_pins_o) && !data_bus_pins_oe_n)
    else $error("Write data not held at write end");

  a_read_access: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(drive_enable_n) |-> !drive_enable_n [*4])
    else $error("Read sampled before access time");

  a_read_resp: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(drive_enable_n) |-> ##[1:8] rsp_valid)
    else $error("Read answer missing");

  a_cycle_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(select_n) |-> select_n [*2])
    else $error("Cycles spaced too closely");

  a_idle_standby: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == ST_IDLE) && !$past(req_valid) |-> select_n && data_bus_pins_oe_n)
    else $error("Not in standby while idle");
endmodule
